// ==== verilog/ccsr_pkg.sv ====
// Purpose: shared constants for the current sampling and rms link
// Assumes: i_clk is the master clock of the metering core
// Notes:   byte-wide link, one command byte then data bytes msb first
package ccsr_pkg;
	localparam int SMP_W  = 24;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 6;
	localparam int REG_W  = 16;
	localparam int TRIM_W = 12;

	// register addresses
	localparam logic [ADDR_W-1:0] A_WAVE   = 6'h01;
	localparam logic [ADDR_W-1:0] A_MODE   = 6'h09;
	localparam logic [ADDR_W-1:0] A_IRQEN  = 6'h0a;
	localparam logic [ADDR_W-1:0] A_STATUS = 6'h0b;
	localparam logic [ADDR_W-1:0] A_RSTAT  = 6'h0c;
	localparam logic [ADDR_W-1:0] A_CURRENT_RMS_RESULT   = 6'h16;
	localparam logic [ADDR_W-1:0] A_CURRENT_RMS_OFFSET_TRIM = 6'h18;

	// command byte and field layout
	localparam int CMD_WR_BIT    = 7;
	localparam int MODE_SRC_LSB  = 13;
	localparam int MODE_RATE_LSB = 11;
	localparam logic [1:0] SRC_CUR_WAVE = 2'h2;
	localparam int IRQ_SAMPLE_READY_IRQ_ENABLE_BIT  = 3;

	// reset values
	localparam logic [REG_W-1:0]  MODE_RST  = 16'h0000;
	localparam logic [REG_W-1:0]  IRQEN_RST = 16'h0000;
	localparam logic [TRIM_W-1:0] TRIM_RST  = 12'h000;

	// timing in master clock cycles
	localparam int WDIV_W = 11;
	localparam logic [WDIV_W-1:0] WAVE_DIV = 11'h080;
	localparam logic [1:0] RMS_DIV_LAST = 2'h3;
	localparam int TRIM_SH = 15;

	// bytes carried by each register
	function automatic logic [1:0] nbytes(input logic [ADDR_W-1:0] a);
		if (a == A_WAVE || a == A_CURRENT_RMS_RESULT) begin
			return 2'h3;
		end else begin
			return 2'h2;
		end
	endfunction

	// move an n-byte word to the top of a 24-bit shifter
	function automatic logic [SMP_W-1:0] align(input logic [SMP_W-1:0] v,
		input logic [1:0] n);
		if (n == 2'h2) begin
			return {v[15:0], 8'h00};
		end else if (n == 2'h1) begin
			return {v[7:0], 16'h0000};
		end else begin
			return v;
		end
	endfunction
endpackage

// ==== verilog/ccsr_if.sv ====
// Purpose: byte link between the metering device and its host
// Assumes: both ends run on the same clock
// Notes:   interrupt line is open drain, pulled high here
`timescale 1ns/1ps
interface ccsr_if;
	logic       sel;
	logic       cmd_valid;
	logic [7:0] cmd_byte;
	logic       cmd_ready;
	logic       rsp_valid;
	logic [7:0] rsp_byte;
	logic       rsp_ready;
	logic       irq_oe;
	logic       irq_n;

	assign irq_n = irq_oe ? 1'b0 : 1'b1;

	modport dev (
		input  sel, cmd_valid, cmd_byte, rsp_ready,
		output cmd_ready, rsp_valid, rsp_byte, irq_oe
	);
	modport host (
		output sel, cmd_valid, cmd_byte, rsp_ready,
		input  cmd_ready, rsp_valid, rsp_byte, irq_n
	);
endinterface

// ==== verilog/ccsr_fifo.sv ====
// Purpose: small synchronous fifo with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   full and empty from pointers with a wrap bit
`timescale 1ns/1ps
module ccsr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_resetn,
	// fill side
	input  wire logic             i_valid,
	input  wire logic [WIDTH-1:0] i_data,
	output logic                  o_ready,
	// drain side
	output logic                  o_valid,
	output logic [WIDTH-1:0]      o_data,
	input  wire logic             i_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp;
	logic [AW:0]      rp;
	logic             full;
	logic             empty;

	assign full    = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
	assign empty   = (wp == rp);
	assign o_ready = !full;
	assign o_valid = !empty;
	assign o_data  = mem[rp[AW-1:0]];

	always_ff @(posedge i_clk) begin
		if (i_valid && !full) begin
			mem[wp[AW-1:0]] <= i_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wp <= '0;
			rp <= '0;
		end else begin
			if (i_valid && !full) begin
				wp <= wp + 1'b1;
			end
			if (i_ready && !empty) begin
				rp <= rp + 1'b1;
			end
		end
	end
endmodule

// ==== verilog/ccsr_device.sv ====
// Purpose: current channel waveform sampling and rms with byte link
// Assumes: i_sample is signed adc data on the master clock
// Notes:   read answers pass an 8 byte fifo; host may stall it
`timescale 1ns/1ps
module ccsr_device
	import ccsr_pkg::*;
#(
	parameter int FIFO_DEPTH = 8,
	parameter int AVG_SH     = 12
) (
	// clock and reset
	input  wire logic                      i_clk,
	input  wire logic                      i_resetn,
	// adc samples
	input  wire logic [ccsr_pkg::SMP_W-1:0] i_sample,
	input  wire logic                      i_sample_valid,
	// host link
	ccsr_if.dev                            lnk
);
	import ccsr_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_WDATA, ST_RDATA} ccsr_state_t;

	ccsr_state_t       state;
	logic [ADDR_W-1:0] addr;
	logic [1:0]        nleft;
	logic [SMP_W-1:0]  wsh;
	logic [SMP_W-1:0]  rsh;
	logic [REG_W-1:0]  mode;
	logic [REG_W-1:0]  irqen;
	logic [TRIM_W-1:0] trim;
	logic              sample_ready_irq_enable_flag;
	logic [SMP_W-1:0]  smp;
	logic [SMP_W-1:0]  wave;
	logic [WDIV_W-1:0] wcnt;
	logic [1:0]        rcnt;
	logic [47:0]       ms;
	logic [SMP_W-1:0]  current_rms_result;
	logic              take;
	logic              is_wr;
	logic              push;
	logic              push_ready;
	logic              wtick;
	logic              rms_tick;
	logic              clr_flag;
	logic [1:0]        rate;
	logic [WDIV_W-1:0] wperiod;
	logic [REG_W-1:0]  status_word;
	logic [SMP_W-1:0]  rd_val;
	logic [SMP_W-1:0]  wr_word;
	logic signed [47:0] sq;
	logic signed [48:0] diff;
	logic signed [49:0] trim_ext;
	logic signed [49:0] corr;
	logic [47:0]        corr_u;

	//--------------------------------------------------------------
	// waveform rate and sample capture
	//--------------------------------------------------------------
	assign rate = mode[MODE_RATE_LSB +: 2];
	assign wperiod = WAVE_DIV << rate;
	assign wtick = (wcnt == wperiod - 1'b1);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wcnt <= '0;
		end else if (wtick) begin
			wcnt <= '0;
		end else begin
			wcnt <= wcnt + 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			smp <= '0;
		end else if (i_sample_valid) begin
			smp <= i_sample;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wave <= '0;
		end else if (wtick && mode[MODE_SRC_LSB +: 2] == SRC_CUR_WAVE) begin
			wave <= smp;
		end
	end

	//--------------------------------------------------------------
	// rms path
	//--------------------------------------------------------------
	// runs in every mode
	assign rms_tick = (rcnt == RMS_DIV_LAST);
	assign sq       = $signed(smp) * $signed(smp);
	assign diff     = $signed({1'b0, sq}) - $signed({1'b0, ms});
	assign trim_ext = 50'(signed'(trim));
	assign corr     = $signed({2'b00, ms}) + (trim_ext <<< TRIM_SH);
	assign corr_u   = corr[49] ? 48'h0 : corr[47:0];

	function automatic logic [SMP_W-1:0] isqrt(input logic [47:0] v);
		logic [SMP_W-1:0] r;
		logic [SMP_W-1:0] t;
		r = '0;
		for (int i = SMP_W - 1; i >= 0; i--) begin
			t = r | (SMP_W'(1) << i);
			if (48'(t) * 48'(t) <= v) begin
				r = t;
			end
		end
		return r;
	endfunction

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rcnt <= '0;
		end else begin
			rcnt <= rcnt + 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ms   <= '0;
			current_rms_result <= '0;
		end else if (rms_tick) begin
			ms   <= 48'($signed({1'b0, ms}) + (diff >>> AVG_SH));
			current_rms_result <= isqrt(corr_u);
		end
	end

	//--------------------------------------------------------------
	// link command engine
	//--------------------------------------------------------------
	assign lnk.cmd_ready = (state != ST_RDATA);
	assign take    = lnk.sel && lnk.cmd_valid && lnk.cmd_ready;
	assign is_wr   = lnk.cmd_byte[CMD_WR_BIT];
	assign push    = (state == ST_RDATA);
	assign wr_word = {wsh[15:0], lnk.cmd_byte};
	assign status_word = REG_W'({sample_ready_irq_enable_flag}) << IRQ_SAMPLE_READY_IRQ_ENABLE_BIT;
	assign clr_flag = take && state == ST_IDLE && !is_wr
		&& lnk.cmd_byte[ADDR_W-1:0] == A_RSTAT;

	always_comb begin
		rd_val = '0;
		if (lnk.cmd_byte[ADDR_W-1:0] == A_WAVE) begin
			rd_val = wave;
		end else if (lnk.cmd_byte[ADDR_W-1:0] == A_MODE) begin
			rd_val = SMP_W'(mode);
		end else if (lnk.cmd_byte[ADDR_W-1:0] == A_IRQEN) begin
			rd_val = SMP_W'(irqen);
		end else if (lnk.cmd_byte[ADDR_W-1:0] == A_STATUS
			|| lnk.cmd_byte[ADDR_W-1:0] == A_RSTAT) begin
			rd_val = SMP_W'(status_word);
		end else if (lnk.cmd_byte[ADDR_W-1:0] == A_CURRENT_RMS_RESULT) begin
			rd_val = current_rms_result;
		end else if (lnk.cmd_byte[ADDR_W-1:0] == A_CURRENT_RMS_OFFSET_TRIM) begin
			rd_val = SMP_W'(signed'(trim));
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= ST_IDLE;
			addr  <= '0;
			nleft <= '0;
			wsh   <= '0;
			rsh   <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (take) begin
						addr  <= lnk.cmd_byte[ADDR_W-1:0];
						nleft <= nbytes(lnk.cmd_byte[ADDR_W-1:0]);
						wsh   <= '0;
						rsh   <= align(rd_val,
							nbytes(lnk.cmd_byte[ADDR_W-1:0]));
						state <= is_wr ? ST_WDATA : ST_RDATA;
					end
				end
				ST_WDATA: begin
					if (!lnk.sel) begin
						state <= ST_IDLE;
					end else if (take) begin
						wsh   <= wr_word;
						nleft <= nleft - 1'b1;
						if (nleft == 2'h1) begin
							state <= ST_IDLE;
						end
					end
				end
				ST_RDATA: begin
					if (push_ready) begin
						rsh   <= {rsh[15:0], 8'h00};
						nleft <= nleft - 1'b1;
						if (nleft == 2'h1) begin
							state <= ST_IDLE;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	//--------------------------------------------------------------
	// registers written by the host
	//--------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			mode  <= MODE_RST;
			irqen <= IRQEN_RST;
			trim  <= TRIM_RST;
		end else if (state == ST_WDATA && take && nleft == 2'h1) begin
			if (addr == A_MODE) begin
				mode <= wr_word[REG_W-1:0];
			end else if (addr == A_IRQEN) begin
				irqen <= wr_word[REG_W-1:0];
			end else if (addr == A_CURRENT_RMS_OFFSET_TRIM) begin
				trim <= wr_word[TRIM_W-1:0];
			end
		end
	end

	//--------------------------------------------------------------
	// sample-ready flag and interrupt line
	//--------------------------------------------------------------
	// flag held until clearing read, set wins
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sample_ready_irq_enable_flag <= 1'b0;
		end else begin
			sample_ready_irq_enable_flag <= (wtick && mode[MODE_SRC_LSB +: 2] == SRC_CUR_WAVE)
				|| (sample_ready_irq_enable_flag && !clr_flag);
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			lnk.irq_oe <= 1'b0;
		end else begin
			lnk.irq_oe <= sample_ready_irq_enable_flag && irqen[IRQ_SAMPLE_READY_IRQ_ENABLE_BIT];
		end
	end

	//--------------------------------------------------------------
	// answer fifo
	//--------------------------------------------------------------
	ccsr_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_rsp_fifo (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_valid  (push),
		.i_data   (rsh[SMP_W-1 -: BYTE_W]),
		.o_ready  (push_ready),
		.o_valid  (lnk.rsp_valid),
		.o_data   (lnk.rsp_byte),
		.i_ready  (lnk.rsp_ready)
	);
endmodule

// ==== verilog/ccsr_host.sv ====
// Purpose: host end, turns word requests into link frames
// Assumes: one request at a time, same clock as the device
// Notes:   rms reads wait for a zero crossing pulse
`timescale 1ns/1ps
module ccsr_host
	import ccsr_pkg::*;
(
	// clock and reset
	input  wire logic                       i_clk,
	input  wire logic                       i_resetn,
	// word requests
	input  wire logic                       i_req_valid,
	input  wire logic                       i_req_write,
	input  wire logic [ccsr_pkg::ADDR_W-1:0] i_req_addr,
	input  wire logic [ccsr_pkg::SMP_W-1:0]  i_req_data,
	output logic                            o_req_ready,
	// read answers
	output logic                            o_rsp_valid,
	output logic [ccsr_pkg::SMP_W-1:0]      o_rsp_data,
	// events
	input  wire logic                       i_zero_cross,
	output logic                            o_irq,
	// device link
	ccsr_if.host                            lnk
);
	import ccsr_pkg::*;

	typedef enum logic [2:0] {H_IDLE, H_CMD, H_WR, H_RD, H_END} ccsr_hstate_t;

	ccsr_hstate_t     state;
	logic [1:0]       n;
	logic [SMP_W-1:0] wsh;
	logic [SMP_W-1:0] acc;
	logic             wr;
	logic             wave_mode;
	logic             gate;
	logic             acc_go;
	logic [SMP_W-1:0] wdata;

	// rms read waits for zero crossing
	assign gate = (i_req_addr != A_CURRENT_RMS_RESULT) || i_zero_cross;
	assign o_req_ready   = (state == H_IDLE) && gate;
	assign acc_go        = i_req_valid && o_req_ready;
	assign lnk.rsp_ready = (state == H_RD);
	// active low line seen as request
	assign o_irq = !lnk.irq_n;

	always_comb begin
		wdata = i_req_data;
		if (i_req_addr == A_IRQEN && wave_mode) begin
			wdata[IRQ_SAMPLE_READY_IRQ_ENABLE_BIT] = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wave_mode <= 1'b0;
		end else if (acc_go && i_req_write && i_req_addr == A_MODE) begin
			wave_mode <= (i_req_data[MODE_SRC_LSB +: 2] == SRC_CUR_WAVE);
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state         <= H_IDLE;
			n             <= '0;
			wsh           <= '0;
			acc           <= '0;
			wr            <= 1'b0;
			lnk.sel       <= 1'b0;
			lnk.cmd_valid <= 1'b0;
			lnk.cmd_byte  <= '0;
			o_rsp_valid   <= 1'b0;
			o_rsp_data    <= '0;
		end else begin
			o_rsp_valid <= 1'b0;
			case (state)
				H_IDLE: begin
					if (acc_go) begin
						n             <= nbytes(i_req_addr);
						wsh           <= align(wdata, nbytes(i_req_addr));
						wr            <= i_req_write;
						acc           <= '0;
						lnk.sel       <= 1'b1;
						lnk.cmd_valid <= 1'b1;
						lnk.cmd_byte  <= {i_req_write, 1'b0, i_req_addr};
						state         <= H_CMD;
					end
				end
				H_CMD: begin
					if (lnk.cmd_ready) begin
						if (wr) begin
							lnk.cmd_byte <= wsh[SMP_W-1 -: BYTE_W];
							wsh          <= {wsh[15:0], 8'h00};
							state        <= H_WR;
						end else begin
							lnk.cmd_valid <= 1'b0;
							state         <= H_RD;
						end
					end
				end
				H_WR: begin
					if (lnk.cmd_ready) begin
						n <= n - 1'b1;
						if (n == 2'h1) begin
							lnk.cmd_valid <= 1'b0;
							state         <= H_END;
						end else begin
							lnk.cmd_byte <= wsh[SMP_W-1 -: BYTE_W];
							wsh          <= {wsh[15:0], 8'h00};
						end
					end
				end
				H_RD: begin
					if (lnk.rsp_valid) begin
						acc <= {acc[15:0], lnk.rsp_byte};
						n   <= n - 1'b1;
						if (n == 2'h1) begin
							o_rsp_valid <= 1'b1;
							o_rsp_data  <= {acc[15:0], lnk.rsp_byte};
							state       <= H_END;
						end
					end
				end
				H_END: begin
					lnk.sel <= 1'b0;
					state   <= H_IDLE;
				end
				default: begin
					state <= H_IDLE;
				end
			endcase
		end
	end
endmodule

// ==== tb/ccsr_asserts.sv ====
// Purpose: link checks between the host and device ends
// Assumes: one clock, reset async active low
// Notes:   a frame starts on the first byte taken with sel newly high
`timescale 1ns/1ps
module ccsr_asserts (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	// link
	input  wire logic       sel,
	input  wire logic       cmd_valid,
	input  wire logic [7:0] cmd_byte,
	input  wire logic       cmd_ready,
	input  wire logic       rsp_valid,
	input  wire logic       rsp_ready,
	input  wire logic       irq_oe
);
	logic        sel_q;
	logic        irq_q;
	logic        seen;
	logic [10:0] gap;
	logic        start;
	logic        clr;
	logic        rise;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	assign start = sel && !sel_q && cmd_valid && cmd_ready;
	assign clr   = start && cmd_byte == 8'h0c;
	assign rise  = irq_oe && !irq_q;

	// ----------------------------------------
	// frame and interrupt history
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sel_q <= 1'b0;
		end else begin
			sel_q <= sel;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			irq_q <= 1'b0;
			seen  <= 1'b0;
			gap   <= 11'h000;
		end else begin
			irq_q <= irq_oe;
			seen  <= seen | rise;
			// saturate so a long quiet spell cannot wrap into a short gap
			if (rise) begin
				gap <= 11'h000;
			end else if (gap != 11'h7ff) begin
				gap <= gap + 11'h001;
			end
		end
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	sequence s_byte;
		rsp_valid && rsp_ready;
	endsequence
	sequence s_three;
		s_byte [*3] ##1 !rsp_valid;
	endsequence
	sequence s_two;
		s_byte [*2] ##1 !rsp_valid;
	endsequence

	property p_rd3;
		start && (cmd_byte == 8'h01 || cmd_byte == 8'h16) |-> ##2 s_three;
	endproperty
	property p_rd2;
		clr |-> ##2 s_two;
	endproperty
	property p_wr_quiet;
		start && cmd_byte[7] |=> !rsp_valid [*4];
	endproperty
	property p_clr;
		clr && irq_oe |-> ##[1:2] !irq_oe;
	endproperty
	property p_irq_fall;
		$fell(irq_oe) |-> $past(clr, 2) || $past(clr, 3);
	endproperty
	property p_irq_grid;
		rise && seen |-> gap[6:0] == 7'h7f;
	endproperty
	property p_irq_gap;
		rise && seen |-> gap >= 11'h07f;
	endproperty
	property p_rsp_frame;
		rsp_valid |-> sel;
	endproperty

	a_rd3: assert property (p_rd3)
		else $error("three byte read answer malformed");
	a_rd2: assert property (p_rd2)
		else $error("status read answer malformed");
	a_wr_quiet: assert property (p_wr_quiet)
		else $error("answer byte during a write");
	a_clr: assert property (p_clr)
		else $error("clearing read left interrupt low");
	a_irq_fall: assert property (p_irq_fall)
		else $error("interrupt released without clearing read");
	a_irq_grid: assert property (p_irq_grid)
		else $error("sample interrupt off the rate grid");
	a_irq_gap: assert property (p_irq_gap)
		else $error("samples closer than 128 clocks");
	a_rsp_frame: assert property (p_rsp_frame)
		else $error("answer byte outside a frame");
endmodule

// ==== tb/tb_top.sv ====
// Purpose: bench for the host and device ends joined by the link
// Assumes: rms averaging shortened through AVG_SH
// Notes:   the sample is held steady while a result is checked
`timescale 1ns/1ps
module tb_top;
	import ccsr_pkg::*;
	logic              i_clk;
	logic              i_resetn;
	logic [SMP_W-1:0]  smp;
	logic              rq_valid;
	logic              rq_write;
	logic [ADDR_W-1:0] rq_addr;
	logic [SMP_W-1:0]  rq_data;
	logic              rq_ready;
	logic              rs_valid;
	logic [SMP_W-1:0]  rs_data;
	logic              zc;
	logic              irq;
	logic [SMP_W-1:0]  got;
	logic [15:0]       rnd;
	logic [15:0]       mode_w;
	logic [11:0]       tv[4];
	logic [ADDR_W-1:0] ra[4];
	time               t0;
	logic              in_tol;
	int                err_count;
	int                tests_run;

	ccsr_if lnk ();
	ccsr_device #(.FIFO_DEPTH(8), .AVG_SH(4)) u_ccsr_device (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_sample(smp),
		.i_sample_valid(1'b1), .lnk(lnk.dev));
	ccsr_host u_ccsr_host (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_req_valid(rq_valid),
		.i_req_write(rq_write), .i_req_addr(rq_addr), .i_req_data(rq_data),
		.o_req_ready(rq_ready), .o_rsp_valid(rs_valid),
		.o_rsp_data(rs_data), .i_zero_cross(zc), .o_irq(irq),
		.lnk(lnk.host));
	ccsr_asserts u_ccsr_asserts (
		.i_clk(i_clk), .i_resetn(i_resetn), .sel(lnk.sel),
		.cmd_valid(lnk.cmd_valid), .cmd_byte(lnk.cmd_byte),
		.cmd_ready(lnk.cmd_ready), .rsp_valid(lnk.rsp_valid),
		.rsp_ready(lnk.rsp_ready), .irq_oe(lnk.irq_oe));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic int exp_rms(input logic [23:0] s, input logic [11:0] t);
		real ms;
		ms = $itor($signed(s)) * $itor($signed(s));
		ms = ms + $itor($signed(t)) * 32768.0;
		return (ms < 0.0) ? 0 : $rtoi($floor($sqrt(ms)));
	endfunction

	task automatic check(input logic [SMP_W-1:0] seen,
		input logic [SMP_W-1:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
		input logic [SMP_W-1:0] d);
		int n;
		n = 0;
		@(negedge i_clk);
		rq_valid = 1'b1;
		rq_write = w;
		rq_addr  = a;
		rq_data  = d;
		zc       = (a == A_CURRENT_RMS_RESULT);
		while (rq_ready !== 1'b1 && n < 2000) begin
			@(negedge i_clk);
			n++;
		end
		@(negedge i_clk);
		rq_valid = 1'b0;
		zc       = 1'b0;
		while (!w && rs_valid !== 1'b1 && n < 2000) begin
			@(negedge i_clk);
			n++;
		end
		got = rs_data;
		if (n >= 2000) begin
			check(24'h0, 24'h1);
			tally_and_finish();
		end
	endtask

	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 2000) begin
			@(negedge i_clk);
			n++;
		end
		check({23'h0, irq}, 24'h1);
		if (n >= 2000) begin
			tally_and_finish();
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ----------------------------------------
	// clock, watchdog and tests
	// ----------------------------------------
	always #4 i_clk = ~i_clk;

	initial begin
		#720000;
		err_count++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		tally_and_finish();
	end

	initial begin
		i_clk = 1'b0;
		i_resetn = 1'b0;
		smp = 24'h000000;
		rq_valid = 1'b0;
		rq_write = 1'b0;
		rq_addr = 6'h00;
		rq_data = 24'h000000;
		zc = 1'b0;
		err_count = 0;
		tests_run = 0;
		rnd = 16'h2502;
		ra = '{A_MODE, A_IRQEN, A_CURRENT_RMS_OFFSET_TRIM, A_CURRENT_RMS_RESULT};
		repeat (16) @(negedge i_clk);
		i_resetn = 1'b1;
		foreach (ra[i]) begin
			xfer(1'b0, ra[i], 24'h0);
			check(got, 24'h000000);
		end
		xfer(1'b0, 6'h3f, 24'h0);
		$display("test reset values done");
		rnd = lfsr(rnd);
		tv = '{12'h7ff, 12'h800, 12'h001, rnd[11:0]};
		foreach (tv[i]) begin
			xfer(1'b1, A_CURRENT_RMS_OFFSET_TRIM, {12'h000, tv[i]});
			xfer(1'b0, A_CURRENT_RMS_OFFSET_TRIM, 24'h0);
			check(got, {8'h00, {4{tv[i][11]}}, tv[i]});
		end
		$display("test trim access done");
		xfer(1'b1, A_IRQEN, 24'h000008);
		xfer(1'b0, A_IRQEN, 24'h0);
		check(got, 24'h000008);
		for (int r = 0; r < 4; r++) begin
			rnd = lfsr(rnd);
			smp = (r == 0) ? 24'h2851ec : (r == 1) ? 24'hd7ae14 :
				{{8{rnd[15]}}, rnd};
			mode_w = 16'h4000 | (16'(r) << MODE_RATE_LSB);
			xfer(1'b1, A_MODE, {8'h00, mode_w});
			xfer(1'b0, A_MODE, 24'h0);
			check(got, {8'h00, mode_w});
			if (r == 0) begin
				// host must keep the sample-ready enable set
				xfer(1'b1, A_IRQEN, 24'h0);
				xfer(1'b0, A_IRQEN, 24'h0);
				check(got, 24'h000008);
			end
			xfer(1'b0, A_RSTAT, 24'h0);
			wait_irq();
			// restart from a clear so the next rise is seen as it happens
			xfer(1'b0, A_RSTAT, 24'h0);
			check({23'h0, irq}, 24'h0);
			wait_irq();
			t0 = $time;
			repeat (20) @(negedge i_clk);
			check({23'h0, irq}, 24'h1);
			xfer(1'b0, A_WAVE, 24'h0);
			check(got, smp);
			xfer(1'b0, A_RSTAT, 24'h0);
			check({23'h0, got[3]}, 24'h1);
			wait_irq();
			check(24'(($time - t0) / 8), 24'(128 << r));
		end
		$display("test waveform rates done");
		smp = 24'he37d4d;
		tv = '{12'h000, 12'h7ff, 12'h800, 12'h000};
		repeat (2000) @(negedge i_clk);
		for (int i = 0; i < 3; i++) begin
			xfer(1'b1, A_CURRENT_RMS_OFFSET_TRIM, {12'h000, tv[i]});
			repeat (8) @(negedge i_clk);
			xfer(1'b0, A_CURRENT_RMS_RESULT, 24'h0);
			t0 = exp_rms(smp, tv[i]);
			in_tol = (got + 24'h2 >= 24'(t0)) && (got <= 24'(t0));
			check({23'h0, in_tol}, 24'h1);
		end
		$display("test rms and trim done");
		tally_and_finish();
	end
endmodule
